// *** core/pmc_pkg.sv ***
// pmc_pkg: constants, register map and types of the prescaler / power mode block
// assumes an apb master with 32-bit data and 8-bit byte addresses
`default_nettype none
package pmc_pkg;
	// register byte offsets
	localparam logic [7:0] PMC_OFS_CTL1 = 8'h00;
	localparam logic [7:0] PMC_OFS_CTL2 = 8'h04;
	localparam logic [7:0] PMC_OFS_MSTBY = 8'h08;
	localparam logic [7:0] PMC_OFS_PINS = 8'h0C;
	localparam logic [7:0] PMC_OFS_DIVSEL = 8'h10;
	localparam logic [7:0] PMC_OFS_CMD = 8'h14;
	localparam logic [7:0] PMC_OFS_STAT = 8'h18;
	// field positions
	localparam int unsigned PMC_STBY_SEL_BIT = 7;
	localparam int unsigned PMC_ACT_DIV_LSB = 0;
	localparam int unsigned PMC_SUB_DIV_LSB = 4;
	localparam int unsigned PMC_PINS_OSC_BIT = 0;
	localparam int unsigned PMC_CMD_SLEEP_BIT = 0;
	localparam int unsigned PMC_CMD_TO_SUB_BIT = 1;
	localparam int unsigned PMC_CMD_TO_ACT_BIT = 2;
	localparam int unsigned PMC_STAT_RUN_BIT = 4;
	localparam int unsigned PMC_STAT_OSC_BIT = 5;
	// widths and counts
	localparam int unsigned PMC_PSC_S_W = 13;
	localparam int unsigned PMC_PSC_W_W = 5;
	localparam int unsigned PMC_NPERIPH = 8;
	localparam int unsigned PMC_TAP_W = 4;
	localparam logic [3:0] PMC_TAP_MAX = 4'hC;
	localparam logic [1:0] PMC_WATCH_DIV_TC = 2'h3; // watch clock divided by four
	// active divider terminal counts (ratio - 1)
	localparam logic [5:0] PMC_TC_DIV1 = 6'h00;
	localparam logic [5:0] PMC_TC_DIV8 = 6'h07;
	localparam logic [5:0] PMC_TC_DIV16 = 6'h0F;
	localparam logic [5:0] PMC_TC_DIV32 = 6'h1F;
	localparam logic [5:0] PMC_TC_DIV64 = 6'h3F;
	// subclock divider terminal counts
	localparam logic [2:0] PMC_TC_SUB2 = 3'h1;
	localparam logic [2:0] PMC_TC_SUB4 = 3'h3;
	localparam logic [2:0] PMC_TC_SUB8 = 3'h7;
	// reset values
	localparam logic [7:0] PMC_CTL1_RST = 8'h00;
	localparam logic [7:0] PMC_CTL2_RST = 8'h00;
	localparam logic [7:0] PMC_MSTBY_RST = 8'h00;
	localparam logic [31:0] PMC_DIVSEL_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		PMC_ACTIVE, PMC_SUBACTIVE, PMC_SLEEP, PMC_SUBSLEEP, PMC_STANDBY
	} pmc_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} pmc_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} pmc_apb_rsp_t;

	typedef struct packed {
		pmc_mode_t mode;
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		logic [7:0] mstby;
		logic pins_osc;
		logic [31:0] divsel;
		logic [12:0] psc_s;
		logic [4:0] psc_w;
		logic [1:0] wdiv;
		logic [5:0] sdiv;
		logic [2:0] subdiv;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic cpu_tick;
		logic [7:0] ptick;
		logic rtc_tick;
		logic osc_en;
	} pmc_state_t;
endpackage
`default_nettype wire

// *** core/pmc_top.sv ***
// pmc_top: system / subclock prescalers, operating mode control, apb registers
// assumes sub_tick_i is a one-cycle pulse per watch clock period, synchronous to clk_i
//
// Added by the designer: the APB slave port and the register offsets.
`default_nettype none

// Behaviour
// R1: system prescaler is a 13-bit up-counter; its taps feed peripheral clocks.
// R2: reset clears the system prescaler; it counts once reset ends.
// R3: main oscillator stops in standby and subsleep.
// R4: in standby or subsleep the system prescaler halts at zero.
// R5: software can neither read nor write the system prescaler count.
// R6: each peripheral picks its own tap of the system prescaler.
// R7: in active and sleep the prescaler input is the divided system clock.
// R8: subclock prescaler is 5 bits, fed by watch clock over four, drives rtc.
// R9: reset clears the subclock prescaler; it counts once reset ends.
// R10: subclock prescaler keeps counting in standby, subactive and subsleep.
// R11: active system clock is oscillator over 1, 8, 16, 32 or 64.
// R12: subactive clock is watch clock over 2, 4 or 8.
// R13: sleep halts the cpu; peripherals keep the system clock.
// R14: subsleep halts the cpu; peripherals run on the subclock.
// R15: standby halts cpu and peripherals; rtc time base keeps going.
// R16: module standby halts single peripherals in any mode.
// R17: standby select bit 7 picks standby or sleep on a sleep command.
// R18: oscillator pins double as port c lines, chosen by a control bit.
// R19: both prescalers wrap to zero after all ones and keep counting.
module pmc_top
	import pmc_pkg::*;
(
	input wire logic clk_i, // 100 MHz system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire pmc_pkg::pmc_apb_req_t apb_i, // apb request
	output logic [$bits(pmc_pkg::pmc_apb_rsp_t)-1:0] apb_o, // apb answer
	input wire logic sub_tick_i, // watch clock pulse
	input wire logic wake_i, // wake event pulse
	output logic cpu_tick_o, // cpu clock enable
	output logic [7:0] periph_tick_o, // per peripheral clock enable
	output logic rtc_tick_o, // rtc time base pulse
	output logic osc_en_o, // main oscillator enable
	output logic osc_pins_sel_o, // 1: pins act as oscillator, 0: port c lines
	output logic [2:0] mode_o // current operating mode
);
	import pmc_pkg::*;

	pmc_state_t s, n;

	////////////////////////////////////////////////////////////////////////////
	// bus decode
	logic acc, wr, rd_hit, sleep_cmd, to_sub_cmd, to_act_cmd;
	assign acc = apb_i.psel && apb_i.penable && !s.pready;
	assign wr = acc && apb_i.pwrite;
	assign sleep_cmd = wr && apb_i.paddr == PMC_OFS_CMD && apb_i.pwdata[PMC_CMD_SLEEP_BIT];
	assign to_sub_cmd = wr && apb_i.paddr == PMC_OFS_CMD && apb_i.pwdata[PMC_CMD_TO_SUB_BIT];
	assign to_act_cmd = wr && apb_i.paddr == PMC_OFS_CMD && apb_i.pwdata[PMC_CMD_TO_ACT_BIT];
	assign rd_hit = apb_i.paddr inside {PMC_OFS_CTL1, PMC_OFS_CTL2, PMC_OFS_MSTBY,
		PMC_OFS_PINS, PMC_OFS_DIVSEL, PMC_OFS_CMD, PMC_OFS_STAT};

	function automatic logic [5:0] act_tc(input logic [2:0] f);
		unique case (f) // [R11]
			3'h1: act_tc = PMC_TC_DIV8;
			3'h2: act_tc = PMC_TC_DIV16;
			3'h3: act_tc = PMC_TC_DIV32;
			3'h4: act_tc = PMC_TC_DIV64;
			default: act_tc = PMC_TC_DIV1;
		endcase
	endfunction

	function automatic logic [2:0] sub_tc(input logic [1:0] f);
		unique case (f) // [R12]
			2'h0: sub_tc = PMC_TC_SUB2;
			2'h1: sub_tc = PMC_TC_SUB4;
			default: sub_tc = PMC_TC_SUB8;
		endcase
	endfunction

	logic sys_en, sub_en, psc_inc, halt_s;
	logic [12:0] psc_nx;
	assign sys_en = s.sdiv == act_tc(s.ctl2[PMC_ACT_DIV_LSB +: 3]);
	assign sub_en = sub_tick_i && s.subdiv == sub_tc(s.ctl2[PMC_SUB_DIV_LSB +: 2]);
	assign halt_s = s.mode inside {PMC_STANDBY, PMC_SUBSLEEP};
	assign psc_inc = s.mode == PMC_SUBACTIVE ? sub_en : sys_en;
	assign psc_nx = s.psc_s + 13'h0001;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [3:0] tap;
		n = s;
		tap = '0;
		// apb: one wait cycle, then pready for one cycle
		n.pready = acc;
		n.pslverr = acc && !rd_hit;
		n.prdata = '0;
		if (acc && !apb_i.pwrite) begin
			unique case (apb_i.paddr)
				PMC_OFS_CTL1: n.prdata = {24'h00_0000, s.ctl1};
				PMC_OFS_CTL2: n.prdata = {24'h00_0000, s.ctl2};
				PMC_OFS_MSTBY: n.prdata = {24'h00_0000, s.mstby};
				PMC_OFS_PINS: n.prdata = {31'h0000_0000, s.pins_osc};
				PMC_OFS_DIVSEL: n.prdata = s.divsel;
				// status shows mode, cpu tick and oscillator enable; prescaler counts have no path [R5]
				PMC_OFS_STAT: n.prdata = {26'h000_0000, s.osc_en, s.cpu_tick, 1'b0, s.mode};
				default: n.prdata = '0;
			endcase
		end
		if (wr) begin
			unique case (apb_i.paddr)
				PMC_OFS_CTL1: n.ctl1 = apb_i.pwdata[7:0]; // [R17]
				PMC_OFS_CTL2: n.ctl2 = apb_i.pwdata[7:0]; // [R7]
				PMC_OFS_MSTBY: n.mstby = apb_i.pwdata[7:0]; // [R16]
				PMC_OFS_PINS: n.pins_osc = apb_i.pwdata[PMC_PINS_OSC_BIT]; // [R18]
				PMC_OFS_DIVSEL: n.divsel = apb_i.pwdata; // [R6]
				default: ;
			endcase
		end

		// operating mode
		unique case (s.mode)
			PMC_ACTIVE, PMC_SUBACTIVE: begin
				if (sleep_cmd) begin
					if (s.ctl1[PMC_STBY_SEL_BIT]) begin
						n.mode = PMC_STANDBY; // [R17]
					end else begin
						n.mode = s.mode == PMC_ACTIVE ? PMC_SLEEP : PMC_SUBSLEEP; // [R17]
					end
				end else if (to_sub_cmd) begin
					n.mode = PMC_SUBACTIVE;
				end else if (to_act_cmd) begin
					n.mode = PMC_ACTIVE;
				end
			end
			PMC_SLEEP, PMC_STANDBY: begin
				if (wake_i) begin
					n.mode = PMC_ACTIVE;
				end
			end
			PMC_SUBSLEEP: begin
				if (wake_i) begin
					n.mode = PMC_SUBACTIVE;
				end
			end
			default: n.mode = PMC_ACTIVE;
		endcase

		// active divider runs off the oscillator clock
		n.sdiv = (sys_en || halt_s) ? 6'h00 : s.sdiv + 6'h01; // [R7] [R11]
		if (sub_tick_i) begin
			n.subdiv = sub_en ? 3'h0 : s.subdiv + 3'h1; // [R12]
		end

		// system prescaler
		if (halt_s) begin
			n.psc_s = '0; // [R4]
		end else if (psc_inc) begin
			n.psc_s = psc_nx; // wraps past all ones [R1] [R19]
		end

		// subclock prescaler never stops outside reset [R10]
		n.rtc_tick = 1'b0;
		if (sub_tick_i) begin
			n.wdiv = s.wdiv + 2'h1;
			if (s.wdiv == PMC_WATCH_DIV_TC) begin
				n.psc_w = s.psc_w + 5'h01; // [R8] [R19]
				n.rtc_tick = &s.psc_w; // [R8] [R15]
			end
		end

		// cpu runs only in active and subactive
		unique case (s.mode)
			PMC_ACTIVE: n.cpu_tick = sys_en; // [R11]
			PMC_SUBACTIVE: n.cpu_tick = sub_en; // [R12]
			default: n.cpu_tick = 1'b0; // [R13] [R14] [R15]
		endcase

		// peripheral clocks: tap rising edge, or subclock in subsleep
		for (int p = 0; p < PMC_NPERIPH; p++) begin
			tap = s.divsel[p*PMC_TAP_W +: PMC_TAP_W];
			if (tap > PMC_TAP_MAX) begin
				tap = PMC_TAP_MAX;
			end
			unique case (s.mode)
				PMC_SUBSLEEP: n.ptick[p] = sub_en; // [R14]
				PMC_STANDBY: n.ptick[p] = 1'b0; // [R15]
				default: n.ptick[p] = psc_inc && psc_nx[tap] && !s.psc_s[tap]; // [R6] [R13]
			endcase
			if (s.mstby[p]) begin
				n.ptick[p] = 1'b0; // [R16]
			end
		end

		// oscillator stopped in deep modes [R3]
		n.osc_en = s.pins_osc && !(n.mode inside {PMC_STANDBY, PMC_SUBSLEEP});
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0; // mode active, both prescalers zero [R2] [R9]
			s.ctl1 <= PMC_CTL1_RST;
			s.ctl2 <= PMC_CTL2_RST;
			s.mstby <= PMC_MSTBY_RST;
			s.divsel <= PMC_DIVSEL_RST;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign apb_o = {s.pready, s.prdata, s.pslverr};
	assign cpu_tick_o = s.cpu_tick;
	assign periph_tick_o = s.ptick;
	assign rtc_tick_o = s.rtc_tick;
	assign osc_en_o = s.osc_en;
	assign osc_pins_sel_o = s.pins_osc;
	assign mode_o = s.mode;

	////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_s_reset;
		$past(rst_i) |-> s.psc_s == '0 && s.mode == PMC_ACTIVE;
	endproperty
	a_s_reset: assert property (p_s_reset) else $error("system prescaler not zero after reset"); // [R2]

	property p_w_reset;
		$past(rst_i) |-> s.psc_w == '0 && s.wdiv == '0;
	endproperty
	a_w_reset: assert property (p_w_reset) else $error("subclock prescaler not zero after reset"); // [R9]

	property p_s_halt;
		halt_s |=> s.psc_s == '0;
	endproperty
	a_s_halt: assert property (p_s_halt) else $error("system prescaler runs in deep mode"); // [R4]

	property p_osc_stop;
		s.mode inside {PMC_STANDBY, PMC_SUBSLEEP} |-> !osc_en_o;
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("oscillator enabled in deep mode"); // [R3]

	property p_s_div;
		s.mode == PMC_ACTIVE && !sys_en |=> s.psc_s == $past(s.psc_s);
	endproperty
	a_s_div: assert property (p_s_div) else $error("prescaler stepped off divided clock"); // [R7]

	property p_s_wrap;
		!halt_s && psc_inc && &s.psc_s |=> s.psc_s == '0;
	endproperty
	a_s_wrap: assert property (p_s_wrap) else $error("system prescaler did not wrap"); // [R19]

	sequence q_w_step;
		sub_tick_i && s.wdiv == PMC_WATCH_DIV_TC;
	endsequence
	property p_w_runs;
		q_w_step |=> s.psc_w == $past(s.psc_w) + 5'h01;
	endproperty
	a_w_runs: assert property (p_w_runs) else $error("subclock prescaler missed a step"); // [R10]

	property p_sleep_halt;
		s.mode inside {PMC_SLEEP, PMC_SUBSLEEP, PMC_STANDBY} |=> !cpu_tick_o;
	endproperty
	a_sleep_halt: assert property (p_sleep_halt) else $error("cpu clocked while halted"); // [R13]

	sequence q_sleep_stby;
		sleep_cmd && s.ctl1[PMC_STBY_SEL_BIT] && s.mode inside {PMC_ACTIVE, PMC_SUBACTIVE};
	endsequence
	property p_stby_sel;
		q_sleep_stby |=> s.mode == PMC_STANDBY ##1 !osc_en_o;
	endproperty
	a_stby_sel: assert property (p_stby_sel) else $error("sleep command missed standby"); // [R17]

	property p_mstby;
		1'b1 |=> ($past(s.mstby) & periph_tick_o) == 8'h00;
	endproperty
	a_mstby: assert property (p_mstby) else $error("halted module still clocked"); // [R16]

	property p_stby_periph;
		s.mode == PMC_STANDBY |=> periph_tick_o == 8'h00;
	endproperty
	a_stby_periph: assert property (p_stby_periph) else $error("peripheral clocked in standby"); // [R15]

	property p_psc_step;
		!halt_s && psc_inc |=> s.psc_s == $past(psc_nx);
	endproperty
	a_psc_step: assert property (p_psc_step) else $error("prescaler missed a step"); // [R1]

	property p_psc_hold;
		!halt_s && !psc_inc |=> s.psc_s == $past(s.psc_s);
	endproperty
	a_psc_hold: assert property (p_psc_hold) else $error("prescaler stepped without input"); // [R1]

	property p_w_hold;
		!(sub_tick_i && s.wdiv == PMC_WATCH_DIV_TC) |=> s.psc_w == $past(s.psc_w);
	endproperty
	a_w_hold: assert property (p_w_hold) else $error("subclock prescaler stepped early"); // [R8]

	property p_w_wrap;
		q_w_step ##0 (&s.psc_w) |=> rtc_tick_o && s.psc_w == 5'h00;
	endproperty
	a_w_wrap: assert property (p_w_wrap) else $error("subclock prescaler did not wrap"); // [R19]

	property p_rtc_src;
		rtc_tick_o |-> s.psc_w == 5'h00 && $past(s.psc_w) == 5'h1F;
	endproperty
	a_rtc_src: assert property (p_rtc_src) else $error("rtc tick without wrap"); // [R8]

	property p_cpu_act;
		s.mode == PMC_ACTIVE |=> cpu_tick_o == $past(sys_en);
	endproperty
	a_cpu_act: assert property (p_cpu_act) else $error("cpu tick off active divider"); // [R11]

	property p_cpu_sub;
		s.mode == PMC_SUBACTIVE |=> cpu_tick_o == $past(sub_en);
	endproperty
	a_cpu_sub: assert property (p_cpu_sub) else $error("cpu tick off subclock divider"); // [R12]

	property p_subsleep_periph;
		s.mode == PMC_SUBSLEEP |=> periph_tick_o == ($past(sub_en) ? ~$past(s.mstby) : 8'h00);
	endproperty
	a_subsleep_periph: assert property (p_subsleep_periph) else $error("subsleep tick wrong"); // [R14]

	sequence q_sleep_act;
		sleep_cmd && !s.ctl1[PMC_STBY_SEL_BIT] && s.mode == PMC_ACTIVE;
	endsequence
	property p_sleep_sel;
		q_sleep_act |=> s.mode == PMC_SLEEP;
	endproperty
	a_sleep_sel: assert property (p_sleep_sel) else $error("sleep command missed sleep"); // [R17]

	sequence q_sleep_sub;
		sleep_cmd && !s.ctl1[PMC_STBY_SEL_BIT] && s.mode == PMC_SUBACTIVE;
	endsequence
	property p_subsleep_sel;
		q_sleep_sub |=> s.mode == PMC_SUBSLEEP;
	endproperty
	a_subsleep_sel: assert property (p_subsleep_sel) else $error("sleep missed subsleep"); // [R17]

	property p_wake_act;
		s.mode inside {PMC_SLEEP, PMC_STANDBY} && wake_i |=> s.mode == PMC_ACTIVE;
	endproperty
	a_wake_act: assert property (p_wake_act) else $error("wake did not reach active"); // [R13]

	property p_wake_sub;
		s.mode == PMC_SUBSLEEP && wake_i |=> s.mode == PMC_SUBACTIVE;
	endproperty
	a_wake_sub: assert property (p_wake_sub) else $error("wake did not reach subactive"); // [R14]

	property p_halt_keep;
		s.mode inside {PMC_SLEEP, PMC_SUBSLEEP, PMC_STANDBY} && !wake_i |=> s.mode == $past(s.mode);
	endproperty
	a_halt_keep: assert property (p_halt_keep) else $error("halted mode left without wake"); // [R13]

	property p_osc_run;
		1'b1 |=> osc_en_o == ($past(s.pins_osc) && !(s.mode inside {PMC_STANDBY, PMC_SUBSLEEP}));
	endproperty
	a_osc_run: assert property (p_osc_run) else $error("oscillator enable wrong"); // [R3]

	property p_pins_osc;
		wr && apb_i.paddr == PMC_OFS_PINS && apb_i.pwdata[PMC_PINS_OSC_BIT] |=> osc_pins_sel_o;
	endproperty
	a_pins_osc: assert property (p_pins_osc) else $error("pins not set to oscillator"); // [R18]

	property p_pins_port;
		wr && apb_i.paddr == PMC_OFS_PINS && !apb_i.pwdata[PMC_PINS_OSC_BIT] |=> !osc_pins_sel_o;
	endproperty
	a_pins_port: assert property (p_pins_port) else $error("pins not set to port lines"); // [R18]

	property p_ctl1_wr;
		wr && apb_i.paddr == PMC_OFS_CTL1 |=>
			{24'h00_0000, s.ctl1} == ($past(apb_i.pwdata) & 32'h0000_00FF);
	endproperty
	a_ctl1_wr: assert property (p_ctl1_wr) else $error("standby select write lost"); // [R17]

	property p_no_count_read;
		acc && !apb_i.pwrite && apb_i.paddr == PMC_OFS_STAT |=>
			s.prdata[31:6] == 26'h000_0000 && !s.prdata[3];
	endproperty
	a_no_count_read: assert property (p_no_count_read) else $error("status shows a count"); // [R5]

	property p_div_idle;
		halt_s |=> s.sdiv == 6'h00;
	endproperty
	a_div_idle: assert property (p_div_idle) else $error("active divider runs in deep mode"); // [R3]

endmodule // pmc_top
`default_nettype wire

// *** test/pmc_tb.sv ***
// pmc_tb: self-checking bench for pmc_top, apb master and tick interval probes
// assumes the watch clock arrives as one sub_tick_i pulse every 4 system clocks
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pmc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sub_tick = 1'b0;
	logic wake = 1'b0;
	logic [1:0] sdiv = 2'h0;
	pmc_apb_req_t req = '0;
	pmc_apb_rsp_t rsp;
	logic [33:0] apb_o_w;
	logic cpu_tick, rtc_tick, osc_en, pins_sel;
	logic [7:0] ptick;
	logic [2:0] mode;
	logic [3:0] probe;
	logic [31:0] rd;
	logic err;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	assign rsp = pmc_apb_rsp_t'(apb_o_w);
	assign probe = {rtc_tick, ptick[1], ptick[0], cpu_tick};
	always #5 clk_i = ~clk_i;
	pmc_top dut (.clk_i(clk_i), .rst_i(rst_i), .apb_i(req), .apb_o(apb_o_w),
		.sub_tick_i(sub_tick), .wake_i(wake), .cpu_tick_o(cpu_tick),
		.periph_tick_o(ptick), .rtc_tick_o(rtc_tick), .osc_en_o(osc_en),
		.osc_pins_sel_o(pins_sel), .mode_o(mode));
	////////////////////////////////////////////////////////////////
	// watch clock stand-in: free running, so the time base never stops
	always @(posedge clk_i) begin
		sdiv <= sdiv + 2'h1;
		sub_tick <= (sdiv == 2'h3);
	end
	// hang guard: ends the run at cycle 60000, above the length of the whole test
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	// outputs are read in the active region of an edge, i.e. the value that edge samples
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge clk_i);
		req.penable <= 1'b1;
		// no wait limit here: the hang guard ends a stuck transfer
		do begin
			@(posedge clk_i);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wait_tick(input int sel);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (probe[sel] !== 1'b1 && n < 20000);
	endtask
	// distance in cycles between two consecutive ticks of one probe
	task automatic gap(input int sel, input int exp);
		int n;
		wait_tick(sel);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (probe[sel] !== 1'b1 && n < 20000);
		chk(n, exp);
	endtask
	task automatic quiet(input int sel, input int cycles);
		int hits;
		hits = 0;
		repeat (cycles) begin
			@(posedge clk_i);
			if (probe[sel] !== 1'b0) hits++;
		end
		chk(hits, 0);
	endtask
	task automatic pulse_wake();
		@(posedge clk_i);
		wake <= 1'b1;
		@(posedge clk_i);
		wake <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] ofs [6] = '{PMC_OFS_CTL1, PMC_OFS_CTL2, PMC_OFS_MSTBY,
			PMC_OFS_PINS, PMC_OFS_DIVSEL, PMC_OFS_STAT};
		foreach (ofs[i]) begin
			apb(1'b0, ofs[i], 32'h0000_0000);
			// active at /1 after reset: status shows a cpu tick every cycle
			chk(rd, (ofs[i] == PMC_OFS_STAT) ? 32'h0000_0010 : 32'h0000_0000);
		end
		apb(1'b0, 8'h1C, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		apb(1'b1, PMC_OFS_CTL1, 32'h0000_0080);
		apb(1'b0, PMC_OFS_CTL1, 32'h0000_0000);
		chk(rd, 32'h0000_0080);
	endtask
	task automatic t_divider();
		int ratio [5] = '{1, 8, 16, 32, 64};
		foreach (ratio[i]) begin
			apb(1'b1, PMC_OFS_CTL2, 32'(i));
			gap(0, ratio[i]);
		end
		apb(1'b1, PMC_OFS_CTL2, 32'h0000_0000);
	endtask
	task automatic t_taps();
		apb(1'b1, PMC_OFS_DIVSEL, 32'h0000_00C0);
		gap(1, 2);
		gap(2, 8192);
		apb(1'b1, PMC_OFS_MSTBY, 32'h0000_0001);
		quiet(1, 40);
		gap(2, 8192);
		apb(1'b1, PMC_OFS_MSTBY, 32'h0000_0000);
	endtask
	task automatic t_modes();
		apb(1'b1, PMC_OFS_PINS, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		chk({pins_sel, osc_en}, 32'h0000_0003);
		apb(1'b1, PMC_OFS_CTL1, 32'h0000_0000);
		apb(1'b1, PMC_OFS_CMD, 32'h0000_0001);
		chk(mode, 32'h0000_0002);
		quiet(0, 40);
		gap(1, 2);
		pulse_wake();
		chk(mode, 32'h0000_0000);
		apb(1'b1, PMC_OFS_CTL1, 32'h0000_0080);
		apb(1'b1, PMC_OFS_CMD, 32'h0000_0001);
		chk(mode, 32'h0000_0004);
		repeat (2) @(posedge clk_i);
		chk(osc_en, 32'h0000_0000);
		quiet(1, 40);
		quiet(0, 40);
		gap(3, 512);
		pulse_wake();
		chk(mode, 32'h0000_0000);
		apb(1'b1, PMC_OFS_CMD, 32'h0000_0002);
		chk(mode, 32'h0000_0001);
		gap(0, 8);
		apb(1'b1, PMC_OFS_CTL2, 32'h0000_0010);
		gap(0, 16);
		apb(1'b1, PMC_OFS_CTL2, 32'h0000_0020);
		gap(0, 32);
		apb(1'b1, PMC_OFS_CTL2, 32'h0000_0000);
		gap(3, 512);
		apb(1'b1, PMC_OFS_CTL1, 32'h0000_0000);
		apb(1'b1, PMC_OFS_CMD, 32'h0000_0001);
		chk(mode, 32'h0000_0003);
		gap(1, 8);
		quiet(0, 40);
		repeat (2) @(posedge clk_i);
		chk(osc_en, 32'h0000_0000);
		gap(3, 512);
		pulse_wake();
		chk(mode, 32'h0000_0001);
		apb(1'b1, PMC_OFS_CMD, 32'h0000_0004);
		chk(mode, 32'h0000_0000);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		gap(3, 512);
		t_reset();
		t_divider();
		t_taps();
		t_modes();
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
